/* hw/ilk_top.sv */
// Interrupt level, keypad wake and pen interrupt block with register port.
// Assumes a single 25 MHz clock; key and pen pins are asynchronous and synchronised here.
// Assumes peripheral requests, external edge modes and core sleep state come from clk logic.
// Assumes software keeps every level field away from 000 and 111.
// Core level, valid, wake and interrupt outputs are registered.
// Read data stands one cycle after the read strobe and reads zero otherwise.
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "ilk_defines.svh"
module ilk_top (
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Peripheral requests, same clock, active high
   input  wire logic        second_timer_request,
   input  wire logic        second_serial_request,
   input  wire logic        second_pulse_request,
   input  wire logic        serial_periph_request,
   // Pins, asynchronous; keys active low, pen active low unless its polarity bit is set
   input  wire logic [7:0]  key_line_b,
   input  wire logic        pen_request_pin,
   // Same-clock configuration and core state
   input  wire logic [3:0]  ext_edge_mode,
   input  wire logic        core_asleep,
   // Outputs
   output logic             pen_pullup_en,
   output logic             core_wake,
   output logic [2:0]       core_level,
   output logic             core_req_valid,
   output logic             irq_out
);

   logic [15:0] level_ctrl_reg;
   logic [15:0] control_reg;
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic [15:0] mask_reg;
   logic [7:0]  key_sync;
   logic        pen_sync;
   logic        pen_prev_reg;
   logic        key_prev_reg;
   logic [3:0]  ext_prev_reg;
   logic [3:0]  ext_fall;
   logic [15:0] rdata_next;
   logic [9:0]  event_vec;
   logic        key_any;
   logic        pen_active;
   logic        pen_edge;
   logic        wr_level;
   logic        wr_ctrl;
   logic        wr_status;
   logic        wr_mask;
   logic [2:0]  lvl_timer;
   logic [2:0]  lvl_serial;
   logic [2:0]  lvl_pulse;
   logic [2:0]  lvl_spi;
   logic [2:0]  best_level;
   ilk_pkg::ilk_bus_req_type  bus;
   ilk_pkg::ilk_core_req_type core_next;

   // Bundle the register port, one driver for the whole struct
   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // Key lines double as level request pins; key lines 0 to 3 also serve as the external interrupt pins
   ilk_sync #(
      .WIDTH   (8),
      .RST_VAL (8'hff)
   ) u_key_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (key_line_b),
      .q     (key_sync)
   );

   // Pen pin idles high through its pull-up
   ilk_sync #(
      .WIDTH   (1),
      .RST_VAL (1'h1)
   ) u_pen_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (pen_request_pin),
      .q     (pen_sync)
   );

   // Pen pin keeps its pull-up enabled
   assign pen_pullup_en = 1'b1;

   // Write decodes
   assign wr_level  = bus.wr && (bus.addr == `ILK_OFS_LEVEL_CTRL);
   assign wr_ctrl   = bus.wr && (bus.addr == `ILK_OFS_CONTROL);
   assign wr_status = bus.wr && (bus.addr == `ILK_OFS_STATUS);
   assign wr_mask   = bus.wr && (bus.addr == `ILK_OFS_MASK);

   // Level control register, reserved bits kept zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level_ctrl_reg <= `ILK_LEVEL_CTRL_RST;
      end else if (wr_level) begin
         level_ctrl_reg <= bus.wdata & `ILK_LEVEL_CTRL_MASK;
      end
   end

   // Control register: pen polarity and both-edge select
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         control_reg <= `ILK_CONTROL_RST;
      end else if (wr_ctrl) begin
         control_reg <= bus.wdata & `ILK_CONTROL_WMASK;
      end
   end

   // Mask register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_reg <= `ILK_MASK_RST;
      end else if (wr_mask) begin
         mask_reg <= bus.wdata & `ILK_EVENT_WMASK;
      end
   end

   // Key request and pen level
   assign key_any    = ~&key_sync;
   assign pen_active = pen_sync ^ ~control_reg[`ILK_CTL_PEN_POL];

   // Previous pen level; reset matches the inactive level
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pen_prev_reg <= 1'b0;
      end else begin
         pen_prev_reg <= pen_active;
      end
   end

   // Previous key request; no key is pressed at reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         key_prev_reg <= 1'b0;
      end else begin
         key_prev_reg <= key_any;
      end
   end

   // Previous external levels; idle high, so no false fall after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_prev_reg <= `ILK_EXT_IDLE;
      end else begin
         ext_prev_reg <= key_sync[3:0];
      end
   end

   // Falling edge of each external input
   assign ext_fall = ext_prev_reg & ~key_sync[3:0];

   // Pen-down edge, or either edge when both-edge mode is set
   assign pen_edge = control_reg[`ILK_CTL_PEN_BOTH] ? (pen_active != pen_prev_reg)
                                                     : (pen_active && !pen_prev_reg);

   // Events into status
   always_comb begin
      event_vec[`ILK_ST_TIMER]  = second_timer_request;
      event_vec[`ILK_ST_SERIAL] = second_serial_request;
      event_vec[`ILK_ST_PULSE]  = second_pulse_request;
      event_vec[`ILK_ST_SPI]    = serial_periph_request;
      event_vec[`ILK_ST_KEY]    = key_any && !key_prev_reg;
      event_vec[`ILK_ST_PEN]    = pen_edge;
      for (int i = 0; i < `ILK_N_EXT; i++) begin
         // Edge mode sets on a fall; level mode follows the low pin
         event_vec[`ILK_ST_EXT0 + i] = ext_edge_mode[i] ? ext_fall[i] : !key_sync[i];
      end
   end

   // Sticky status: set wins over write-one-to-clear
   always_comb begin
      status_next = status_reg;
      if (wr_status) begin
         status_next = status_reg & ~bus.wdata;
      end
      // Level-mode external bits drop once the pin is back high
      for (int i = 0; i < `ILK_N_EXT; i++) begin
         if (!ext_edge_mode[i] && key_sync[i]) begin
            status_next[`ILK_ST_EXT0 + i] = 1'b0;
         end
      end
      status_next[15:10] = 6'h00;
      status_next[9:0]   = status_next[9:0] | event_vec;
   end

   // Status register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_reg <= `ILK_STATUS_RST;
      end else begin
         status_reg <= status_next;
      end
   end

   // Level fields
   assign lvl_timer  = level_ctrl_reg[`ILK_LVL_TIMER_LSB  +: 3];
   assign lvl_serial = level_ctrl_reg[`ILK_LVL_SERIAL_LSB +: 3];
   assign lvl_pulse  = level_ctrl_reg[`ILK_LVL_PULSE_LSB  +: 3];
   assign lvl_spi    = level_ctrl_reg[`ILK_LVL_SPI_LSB    +: 3];

   // Keep the higher of a running best and a candidate; 000 and 111 never win
   function automatic logic [2:0] pick(
      input logic [2:0] best,
      input logic       pend,
      input logic [2:0] lvl
   );
      logic ok;
      ok = pend && (lvl != 3'h0) && (lvl != 3'h7);
      pick = (ok && (lvl > best)) ? lvl : best;
   endfunction

   // Highest enabled pending level
   always_comb begin
      logic [15:0] act;
      act = status_reg & mask_reg;
      best_level = 3'h0;
      best_level = pick(best_level, act[`ILK_ST_TIMER],  lvl_timer);
      best_level = pick(best_level, act[`ILK_ST_SERIAL], lvl_serial);
      best_level = pick(best_level, act[`ILK_ST_PULSE],  lvl_pulse);
      best_level = pick(best_level, act[`ILK_ST_SPI],    lvl_spi);
      best_level = pick(best_level, act[`ILK_ST_KEY],    `ILK_KEY_LEVEL);
      best_level = pick(best_level, act[`ILK_ST_PEN],    `ILK_PEN_LEVEL);
      for (int i = 0; i < `ILK_N_EXT; i++) begin
         best_level = pick(best_level, act[`ILK_ST_EXT0 + i], `ILK_KEY_LEVEL);
      end
      core_next.level = best_level;
      core_next.valid = (best_level != 3'h0);
   end

   // Registered core request
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_level     <= 3'h0;
         core_req_valid <= 1'b0;
      end else begin
         core_level     <= core_next.level;
         core_req_valid <= core_next.valid;
      end
   end

   // Wake a sleeping core on any pressed key
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_wake <= 1'b0;
      end else begin
         core_wake <= core_asleep && key_any;
      end
   end

   // Level interrupt, same timing as the status register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(status_next[9:0] & mask_reg[9:0]);
      end
   end

   // Read mux; unmapped addresses and idle cycles read zero
   always_comb begin
      rdata_next = 16'h0000;
      if (bus.rd) begin
         unique case (bus.addr)
            `ILK_OFS_LEVEL_CTRL: rdata_next = level_ctrl_reg;
            `ILK_OFS_CONTROL:    rdata_next = control_reg;
            `ILK_OFS_STATUS:     rdata_next = status_reg;
            `ILK_OFS_MASK:       rdata_next = mask_reg;
            `ILK_OFS_RAW:        rdata_next = {6'h00, pen_sync, key_any, key_sync};
            default:             rdata_next = 16'h0000;
         endcase
      end
   end

   // Read data one cycle after the strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= rdata_next;
      end
   end

endmodule

/* hw/ilk_defines.svh */
// Offsets, field positions, reset values and sizes of the level/keypad/pen block.
// Assumes a 16-bit register port with word indices as addresses.
`ifndef ILK_DEFINES_SVH
`define ILK_DEFINES_SVH

`define ILK_ADDR_W          4
`define ILK_DATA_W          16
// Register addresses
`define ILK_OFS_LEVEL_CTRL  4'h0
`define ILK_OFS_CONTROL     4'h1
`define ILK_OFS_STATUS      4'h2
`define ILK_OFS_MASK        4'h3
`define ILK_OFS_RAW         4'h4
// Level field positions in the level control register
`define ILK_LVL_TIMER_LSB   12
`define ILK_LVL_SERIAL_LSB  8
`define ILK_LVL_PULSE_LSB   4
`define ILK_LVL_SPI_LSB     0
// Reset value: timer 3, serial 5, pulse 3, spi 6
`define ILK_LEVEL_CTRL_RST  16'h3536
`define ILK_LEVEL_CTRL_MASK 16'h7777
// Control register bits
`define ILK_CTL_PEN_POL     0
`define ILK_CTL_PEN_BOTH    1
`define ILK_CONTROL_RST     16'h0000
`define ILK_CONTROL_WMASK   16'h0003
// Status bit positions
`define ILK_ST_TIMER        0
`define ILK_ST_SERIAL       1
`define ILK_ST_PULSE        2
`define ILK_ST_SPI          3
`define ILK_ST_KEY          4
`define ILK_ST_PEN          5
`define ILK_ST_EXT0         6
`define ILK_N_EVENTS        10
`define ILK_N_EXT           4
`define ILK_MASK_RST        16'h0000
`define ILK_EVENT_WMASK     16'h03ff
`define ILK_STATUS_RST      16'h0000
// External pins idle high
`define ILK_EXT_IDLE        4'hf
// Fixed levels
`define ILK_PEN_LEVEL       3'h5
`define ILK_KEY_LEVEL       3'h4
`define ILK_N_KEYS          8

`endif

/* hw/ilk_pkg.sv */
// Types of the level/keypad/pen interrupt block.
// Assumes ilk_defines.svh is compiled alongside.
package ilk_pkg;

   // Register port request
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ilk_bus_req_type;

   // Request presented to the core
   typedef struct packed {
      logic       valid;
      logic [2:0] level;
   } ilk_core_req_type;

endpackage

/* hw/ilk_sync.sv */
// Two-flop synchroniser, parameterised in width.
// Assumes inputs come from pins outside the clk domain.
`timescale 1ns/10ps
module ilk_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] first_reg;

   // First stage feeds only the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         first_reg <= RST_VAL;
         q         <= RST_VAL;
      end else begin
         first_reg <= d;
         q         <= first_reg;
      end
   end

endmodule

/* bench/ilk_top_sva.sv */
// Port assertions for the level/keypad/pen block.
// Assumes a bind in tb connecting every port by name.
`timescale 1ns/10ps
module ilk_top_sva (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [7:0]  key_line_b,
   input wire logic        core_asleep,
   input wire logic        pen_pullup_en,
   input wire logic        core_wake,
   input wire logic [2:0]  core_level,
   input wire logic        core_req_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Level write followed by its read back
   sequence lvl_wr_rd;
      reg_wr && reg_addr == 4'h0 ##2 reg_rd && reg_addr == 4'h0;
   endsequence
   chk_lvl_readback: assert property (lvl_wr_rd |=> reg_rdata == ($past(reg_wdata, 3) & 16'h7777))
      else $error("level readback wrong");
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero");
   chk_unmapped_zero: assert property (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_valid_match: assert property (core_req_valid == (core_level != 3'h0))
      else $error("valid and level disagree");
   chk_level_legal: assert property (core_req_valid |-> core_level inside {[3'h1:3'h6]})
      else $error("illegal core level");
   chk_pullup_on: assert property (pen_pullup_en)
      else $error("pen pull-up off");
   chk_key_wake: assert property ((core_asleep && key_line_b != 8'hff) [*4] |-> core_wake)
      else $error("key press did not wake");
   chk_awake_quiet: assert property (!core_asleep |=> !core_wake)
      else $error("wake while awake");
endmodule

/* bench/ilk_core_model.sv */
// Core model: sleeps from reset, wakes on request, takes levels.
// Assumes the same clock and reset as the block.
`timescale 1ns/10ps
module ilk_core_model (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       core_wake,
   input  wire logic       core_req_valid,
   input  wire logic [2:0] core_level,
   output logic            core_asleep,
   output logic      [2:0] taken_level
);
   // Leave sleep on the wake line
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         core_asleep <= 1'b1;
      else if (core_wake)
         core_asleep <= 1'b0;
   end
   // Take the presented level
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         taken_level <= 3'h0;
      else if (core_req_valid)
         taken_level <= core_level;
   end
endmodule

/* bench/tb.sv */
// Self-checking bench for the level/keypad/pen block.
// Assumes ilk_top, ilk_core_model and ilk_top_sva are compiled first.
`timescale 1ns/10ps
module tb;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [3:0]  req = 4'h0;
   logic [7:0]  key_line_b = 8'hff;
   logic        pen_request_pin = 1'b1;
   logic [3:0]  ext_edge_mode = 4'h1;
   logic [15:0] reg_rdata, rd_val;
   logic [2:0]  core_level, taken_level;
   logic        core_asleep, pen_pullup_en, core_wake, core_req_valid, irq_out;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   always #20 clk = ~clk;
   ilk_top i_ilk_top (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .second_timer_request(req[0]), .second_serial_request(req[1]),
      .second_pulse_request(req[2]), .serial_periph_request(req[3]), .key_line_b(key_line_b),
      .pen_request_pin(pen_request_pin), .ext_edge_mode(ext_edge_mode), .core_asleep(core_asleep),
      .pen_pullup_en(pen_pullup_en), .core_wake(core_wake), .core_level(core_level),
      .core_req_valid(core_req_valid), .irq_out(irq_out));
   ilk_core_model i_ilk_core_model (.clk(clk), .rst_b(rst_b), .core_wake(core_wake),
      .core_req_valid(core_req_valid), .core_level(core_level), .core_asleep(core_asleep),
      .taken_level(taken_level));
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // One-cycle read, data taken in the next cycle
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   // One-cycle request pulse, then one more cycle to the core
   task automatic pulse(input logic [3:0] m);
      @(posedge clk);
      req <= m;
      @(posedge clk);
      req <= 4'h0;
      @(posedge clk);
      #1;
   endtask
   task automatic test_done;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         test_done();
      end
   end
   // Main sequence
   initial begin
      logic [15:0] lv [4];
      lv = '{16'h3, 16'h5, 16'h3, 16'h6};
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd(i[3:0]);
         check(rd_val, (i == 0) ? 16'h3536 : 16'h0000);
      end
      rd(4'hf);
      check(rd_val, 16'h0000);
      $display("reset test done");
      wr(4'h3, 16'hffff);
      rd(4'h3);
      check(rd_val, 16'h03ff);
      for (int i = 0; i < 4; i++) begin
         pulse(4'h1 << i);
         check({13'h0, core_level}, lv[i]);
         check({15'h0, irq_out}, 16'h0001);
         wr(4'h2, 16'h000f);
      end
      $display("source test done");
      wr(4'h0, 16'h1246);
      rd(4'h0);
      check(rd_val, 16'h1246);
      pulse(4'h3);
      check({13'h0, core_level}, 16'h0002);
      wr(4'h0, 16'he246);
      rd(4'h0);
      check(rd_val, 16'h6246);
      check({13'h0, core_level}, 16'h0006);
      check({13'h0, taken_level}, 16'h0006);
      rd(4'h2);
      check(rd_val, 16'h0003);
      wr(4'h2, 16'h000f);
      $display("level test done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) key_line_b <= ~(8'h01 << i);
         repeat (4) @(posedge clk);
         rd(4'h4);
         check(rd_val, {6'h0, 2'b11, ~(8'h01 << i)});
         check({13'h0, core_level}, 16'h0004);
         @(posedge clk) key_line_b <= 8'hff;
         repeat (4) @(posedge clk);
      end
      #1 check({15'h0, core_asleep}, 16'h0000);
      rd(4'h2);
      check(rd_val, 16'h0050);
      wr(4'h2, 16'h03ff);
      rd(4'h2);
      check(rd_val, 16'h0000);
      $display("key test done");
      @(posedge clk) pen_request_pin <= 1'b0;
      repeat (6) @(posedge clk);
      #1 check({13'h0, core_level}, 16'h0005);
      wr(4'h2, 16'h0020);
      @(posedge clk) pen_request_pin <= 1'b1;
      repeat (6) @(posedge clk);
      rd(4'h2);
      check(rd_val, 16'h0000);
      wr(4'h1, 16'h0003);
      rd(4'h1);
      check(rd_val, 16'h0003);
      repeat (2) @(posedge clk);
      wr(4'h2, 16'h03ff);
      @(posedge clk) pen_request_pin <= 1'b0;
      repeat (6) @(posedge clk);
      rd(4'h2);
      check(rd_val, 16'h0020);
      wr(4'h2, 16'h03ff);
      $display("pen test done");
      wr(4'h3, 16'h0000);
      pulse(4'h1);
      check({14'h0, irq_out, core_req_valid}, 16'h0000);
      wr(4'h3, 16'h0001);
      rd(4'h2);
      check({15'h0, irq_out}, 16'h0001);
      wr(4'h2, 16'h0001);
      rd(4'h2);
      check({15'h0, irq_out}, 16'h0000);
      $display("mask test done");
      @(posedge clk) pen_request_pin <= 1'b1;
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(4'h0);
      check(rd_val, 16'h3536);
      rd(4'h2);
      check(rd_val, 16'h0000);
      check({14'h0, core_asleep, core_req_valid}, 16'h0002);
      $display("second reset test done");
      test_done();
   end
endmodule
bind ilk_top ilk_top_sva i_ilk_top_sva (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_line_b(key_line_b), .core_asleep(core_asleep),
   .pen_pullup_en(pen_pullup_en), .core_wake(core_wake), .core_level(core_level),
   .core_req_valid(core_req_valid));
